/* hdl/fap_regs.vh */
`ifndef FAP_REGS_VH
`define FAP_REGS_VH

// ==========================================================================
// Flash geometry
`define FAP_ADDR_W 16
`define FAP_PAGE_SHIFT 9
`define FAP_PAGE_BYTES 512
`define FAP_LOCK_ADDR 16'h1FFF
`define FAP_RSVD_BASE 16'h2000
`define FAP_LOCK_RESET 8'hFF

// ==========================================================================
// Key codes
`define FAP_KEY1 8'hA5
`define FAP_KEY2 8'hF1

// ==========================================================================
// Operation codes
`define FAP_OP_READ 2'h0
`define FAP_OP_WRITE 2'h1
`define FAP_OP_ERASE 2'h2

`endif

/* hdl/fap_flash_access_protection.v */
`timescale 1ns/1ps
`include "fap_regs.vh"

// What this block does
// RQ1: Firmware flash writes refused unless program store write enable is set.
// RQ2: Firmware erase allowed only with write enable and erase enable set.
// RQ3: Lock byte at last user byte locks inverse-count pages from page 0.
// RQ4: Lock byte page is locked when any lock byte bit is zero.
// RQ5: Unlocked ordinary pages are open to debug port and all firmware.
// RQ6: Locked pages: debug refused, unlocked firmware resets, locked firmware ok.
// RQ7: Lock page access while locked: debug refused, unlocked firmware resets.
// RQ8: Lock page erase when unlocked: debug allowed, firmware always resets.
// RQ9: While locked, lock page erases only via debug whole-device erase.
// RQ10: Changing lock byte bits: debug refused, firmware causes flash reset.
// RQ11: Reserved area access: debug refused, firmware causes flash reset.
// RQ12: Flash fault reset flag reads one after a flash error reset.
// RQ13: Prohibited debug operations are dropped silently, no reset.
// RQ14: Once written, lock byte changes only by debug whole-device erase.
// RQ15: Firmware lock byte writes take effect only after next reset.
// RQ16: Scratchpad is locked when all other pages are locked.
// RQ17: Whole-device erase also erases the scratchpad.
// RQ18: Firmware writes key codes in order before each write or erase.
// RQ19: Key relocks after each operation; bad key disables until reset.
// RQ20: Firmware write or erase without supply monitor causes flash reset.
// RQ21: Firmware page lock state is judged from the issuing instruction address.
module fap_flash_access_protection #(
  parameter ADDR_W = `FAP_ADDR_W,
  parameter PAGE_SHIFT = `FAP_PAGE_SHIFT
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire por_i,
  input wire [7:0] lock_byte_i,
  input wire program_store_write_en_i,
  input wire program_store_erase_en_i,
  input wire supply_mon_en_i,
  input wire supply_mon_rst_src_i,
  input wire key_wr_i,
  input wire [7:0] key_data_i,
  input wire fw_req_i,
  input wire [1:0] fw_op_i,
  input wire [ADDR_W-1:0] fw_addr_i,
  input wire [ADDR_W-1:0] fw_pc_i,
  input wire fw_scratch_i,
  input wire dbg_req_i,
  input wire [1:0] dbg_op_i,
  input wire [ADDR_W-1:0] dbg_addr_i,
  input wire dbg_scratch_i,
  input wire debug_port_full_erase_i,
  output reg fw_grant_o,
  output reg dbg_grant_o,
  output reg full_erase_grant_o,
  output reg flash_error_reset_o,
  output reg flash_fault_reset_flag_o,
  output reg [7:0] lock_count_o,
  output reg key_open_o,
  output reg key_dead_o
);

  // ========================================================================
  // Local state
  localparam KEY_IDLE = 2'h0;
  localparam KEY_HALF = 2'h1;
  localparam KEY_OPEN = 2'h2;
  localparam KEY_DEAD = 2'h3;

  reg [7:0] lock_r;
  reg [1:0] key_r;
  reg [1:0] key_nxt;
  reg fault_r;
  reg rst_d_r;
  reg fw_ok;
  reg fw_err;
  reg dbg_ok;
  reg key_use;
  wire any_lock;
  wire all_lock;
  wire fw_mod;
  wire [ADDR_W-1:0] lock_addr;

  assign lock_addr = `FAP_LOCK_ADDR;
  assign any_lock = (lock_r != 8'hFF); // see RQ4
  assign all_lock = (lock_r == 8'h00) ||
    ((~lock_r) >= lock_addr[ADDR_W-1:PAGE_SHIFT]); // see RQ16
  assign fw_mod = fw_op_i != `FAP_OP_READ;

  // ========================================================================
  // Address classification
  function fap_in_lock;
    input [ADDR_W-1:0] a;
    input [7:0] lb;
    reg [ADDR_W-1:0] pg;
    begin
      pg = a >> PAGE_SHIFT;
      fap_in_lock = pg < {{(ADDR_W-8){1'b0}}, ~lb}; // see RQ3
    end
  endfunction

  function fap_lock_pg;
    input [ADDR_W-1:0] a;
    reg [ADDR_W-1:0] la;
    begin
      la = `FAP_LOCK_ADDR;
      fap_lock_pg = (a >> PAGE_SHIFT) == (la >> PAGE_SHIFT);
    end
  endfunction

  function fap_rsvd;
    input [ADDR_W-1:0] a;
    reg [ADDR_W-1:0] rb;
    begin
      rb = `FAP_RSVD_BASE;
      fap_rsvd = a >= rb;
    end
  endfunction

  // ========================================================================
  // Lock byte sampled only at device reset
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      lock_r <= lock_byte_i; // see RQ15
    end
  end

  // ========================================================================
  // Firmware decision
  always @* begin
    fw_ok = 1'b0;
    fw_err = 1'b0;
    key_use = 1'b0;
    if (fw_req_i) begin
      if (fap_rsvd(fw_addr_i)) begin
        fw_err = 1'b1; // see RQ11
      end else if (fw_mod && !(supply_mon_en_i && supply_mon_rst_src_i)) begin
        fw_err = 1'b1; // see RQ20
      end else if (fw_op_i == `FAP_OP_ERASE && fap_lock_pg(fw_addr_i)) begin
        fw_err = 1'b1; // see RQ8 see RQ9
      end else if (fw_op_i == `FAP_OP_WRITE && fw_addr_i == lock_addr &&
                   lock_byte_i != 8'hFF) begin
        fw_err = 1'b1; // see RQ10 see RQ14
      end else if ((fw_scratch_i ? all_lock :
                   (fap_lock_pg(fw_addr_i) ? any_lock :
                   fap_in_lock(fw_addr_i, lock_r))) &&
                   !(any_lock && (fap_in_lock(fw_pc_i, lock_r) ||
                   fap_lock_pg(fw_pc_i)))) begin
        fw_err = 1'b1; // see RQ6 see RQ7 see RQ21
      end else if (fw_mod) begin
        key_use = 1'b1;
        fw_ok = program_store_write_en_i && key_r == KEY_OPEN &&
          (fw_op_i != `FAP_OP_ERASE ||
          program_store_erase_en_i); // see RQ1 see RQ2 see RQ19
      end else begin
        fw_ok = 1'b1; // see RQ5
      end
    end
  end

  // ========================================================================
  // Debug port decision, never resets
  always @* begin
    dbg_ok = 1'b0;
    if (dbg_req_i && !fap_rsvd(dbg_addr_i)) begin // see RQ11 see RQ13
      if (dbg_scratch_i) begin
        dbg_ok = !all_lock; // see RQ16
      end else if (fap_lock_pg(dbg_addr_i)) begin
        if (dbg_op_i == `FAP_OP_WRITE && dbg_addr_i == lock_addr) begin
          dbg_ok = lock_byte_i == 8'hFF && !any_lock; // see RQ10 see RQ14
        end else begin
          dbg_ok = !any_lock; // see RQ7 see RQ8 see RQ9
        end
      end else begin
        dbg_ok = !fap_in_lock(dbg_addr_i, lock_r); // see RQ5 see RQ6
      end
    end
  end

  // ========================================================================
  // Key sequencer
  always @* begin
    key_nxt = key_r;
    case (key_r)
      KEY_IDLE: begin
        if (key_wr_i) begin
          key_nxt = (key_data_i == `FAP_KEY1) ? KEY_HALF : KEY_DEAD;
        end else if (key_use) begin
          key_nxt = KEY_DEAD; // see RQ19
        end
      end
      KEY_HALF: begin
        if (key_wr_i) begin
          key_nxt = (key_data_i == `FAP_KEY2) ? KEY_OPEN : KEY_DEAD;
        end else if (key_use) begin
          key_nxt = KEY_DEAD;
        end
      end
      KEY_OPEN: begin
        if (key_wr_i) begin
          key_nxt = KEY_DEAD;
        end else if (key_use) begin
          key_nxt = KEY_IDLE; // see RQ18 see RQ19
        end
      end
      default: begin
        key_nxt = KEY_DEAD;
      end
    endcase
  end

  // ========================================================================
  // Registers and outputs
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      key_r <= KEY_IDLE;
      fw_grant_o <= 1'b0;
      dbg_grant_o <= 1'b0;
      full_erase_grant_o <= 1'b0;
      flash_error_reset_o <= 1'b0;
      key_open_o <= 1'b0;
      key_dead_o <= 1'b0;
      lock_count_o <= 8'h00;
    end else begin
      key_r <= key_nxt;
      fw_grant_o <= fw_ok;
      dbg_grant_o <= dbg_ok;
      full_erase_grant_o <= debug_port_full_erase_i; // see RQ9 see RQ17
      flash_error_reset_o <= fw_err;
      key_open_o <= key_nxt == KEY_OPEN;
      key_dead_o <= key_nxt == KEY_DEAD;
      lock_count_o <= ~lock_r;
    end
  end

  // Delayed reset marks the first cycle of a reset pulse
  always @(posedge sys_clk_i) begin
    rst_d_r <= reset_i;
  end

  // Reset cause flag survives the flash error reset it reports
  // Only the first reset cycle loads it, so a long reset keeps the cause
  always @(posedge sys_clk_i) begin
    if (por_i) begin
      fault_r <= 1'b0;
      flash_fault_reset_flag_o <= 1'b0;
    end else if (reset_i) begin
      fault_r <= 1'b0;
      if (!rst_d_r) begin
        flash_fault_reset_flag_o <= fault_r | fw_err; // see RQ12
      end
    end else if (fw_err) begin
      fault_r <= 1'b1;
    end
  end

endmodule

/* verification/fap_props.sv */
`timescale 1ns/1ps
`include "fap_regs.vh"
// ==========
// Checker on the top ports
module fap_props #(
  parameter ADDR_W = 16
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire fw_req_i,
  input wire [1:0] fw_op_i,
  input wire [ADDR_W-1:0] fw_addr_i,
  input wire fw_scratch_i,
  input wire program_store_write_en_i,
  input wire key_wr_i,
  input wire [7:0] key_data_i,
  input wire dbg_req_i,
  input wire fw_grant_o,
  input wire dbg_grant_o,
  input wire flash_error_reset_o,
  input wire key_open_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire wr_op = fw_req_i && fw_op_i != `FAP_OP_READ;
  // Properties
  chk_wen_gate: assert property (wr_op && !program_store_write_en_i
    |=> !fw_grant_o) else $error("write granted without enable");
  chk_dbg_silent: assert property (flash_error_reset_o
    |-> $past(fw_req_i)) else $error("fault reset without firmware");
  chk_grant_excl: assert property (!(fw_grant_o && flash_error_reset_o))
    else $error("grant and fault together");
  chk_rsvd_fault: assert property (fw_req_i && fw_op_i == `FAP_OP_READ
    && fw_addr_i >= `FAP_RSVD_BASE && !fw_scratch_i |=> flash_error_reset_o)
    else $error("reserved read without fault");
  chk_key_order: assert property ($rose(key_open_o)
    |-> $past(key_wr_i && key_data_i == `FAP_KEY2)) else $error("key order");
  chk_key_relock: assert property (key_open_o && wr_op |=> !key_open_o)
    else $error("key stays open");
  chk_fw_source: assert property (fw_grant_o |-> $past(fw_req_i))
    else $error("firmware grant without request");
  chk_dbg_source: assert property (dbg_grant_o |-> $past(dbg_req_i))
    else $error("debug grant without request");
  cover property (fw_grant_o);
  cover property (flash_error_reset_o);
  cover property (key_open_o ##1 !key_open_o);
endmodule

bind fap_flash_access_protection fap_props #(.ADDR_W(ADDR_W)) u_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .fw_req_i(fw_req_i),
  .fw_op_i(fw_op_i), .fw_addr_i(fw_addr_i), .fw_scratch_i(fw_scratch_i),
  .program_store_write_en_i(program_store_write_en_i),
  .key_wr_i(key_wr_i), .key_data_i(key_data_i), .dbg_req_i(dbg_req_i),
  .fw_grant_o(fw_grant_o), .dbg_grant_o(dbg_grant_o),
  .flash_error_reset_o(flash_error_reset_o), .key_open_o(key_open_o));

/* verification/fap_key_host.sv */
`timescale 1ns/1ps
`include "fap_regs.vh"
// Firmware model: two key writes on back-to-back cycles
module fap_key_host (
  input wire sys_clk_i,
  input wire unlock_i,
  input wire bad_i,
  output logic key_wr_o = 1'h0,
  output logic [7:0] key_data_o = 8'h00
);
  logic second_r = 1'h0;
  // Key sequence, data toggles while idle
  always @(posedge sys_clk_i) begin
    second_r <= unlock_i;
    key_wr_o <= unlock_i | second_r;
    key_data_o <= unlock_i ? (bad_i ? `FAP_KEY2 : `FAP_KEY1) :
      second_r ? `FAP_KEY2 : ~key_data_o;
  end
endmodule

/* verification/test_flash_access_protection.sv */
`timescale 1ns/1ps
`include "fap_regs.vh"
module test_flash_access_protection;
  logic clk = 0, rst = 1, por = 1, fq = 0, dq = 0, we = 1, ee = 0, un = 0;
  logic [1:0] fo = 0, dop = 0;
  logic sm = 1;
  logic [7:0] lb = 8'hFC;
  logic [15:0] fa = 0, pc = 0, da = 0;
  logic [31:0] rs = 32'h5073;
  wire kw, fg, dg, fr, ff, ko, kd;
  wire [7:0] kv, lc;
  int err_count = 0, n_checks = 0, cyc = 0;
  int n = 3;
  fap_key_host host_u (.sys_clk_i(clk), .unlock_i(un), .bad_i(1'h0),
    .key_wr_o(kw), .key_data_o(kv));
  fap_flash_access_protection dut_u (.sys_clk_i(clk), .reset_i(rst),
    .por_i(por), .lock_byte_i(lb), .program_store_write_en_i(we),
    .program_store_erase_en_i(ee), .supply_mon_en_i(sm),
    .supply_mon_rst_src_i(1'h1), .key_wr_i(kw), .key_data_i(kv),
    .fw_req_i(fq), .fw_op_i(fo), .fw_addr_i(fa), .fw_pc_i(pc),
    .fw_scratch_i(1'h0), .dbg_req_i(dq), .dbg_op_i(dop), .dbg_addr_i(da),
    .dbg_scratch_i(1'h0), .debug_port_full_erase_i(1'h0), .fw_grant_o(fg),
    .dbg_grant_o(dg), .full_erase_grant_o(), .flash_error_reset_o(fr),
    .flash_fault_reset_flag_o(ff), .lock_count_o(lc), .key_open_o(ko),
    .key_dead_o(kd));
  initial forever #12.5 clk = ~clk;
  // Cut a hang short
  always @(posedge clk) if (++cyc == 3000) begin
    err_count++;
    complete_run;
  end
  function automatic bit lkd(logic [15:0] a);
    return a[15:9] < n || (a[15:9] == 7'h0F && n != 0);
  endfunction
  task automatic chk(string nm, logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic fw(logic [1:0] o, logic [15:0] a, p, logic [1:0] e);
    @(posedge clk) {fo, fa, pc, fq} <= {o, a, p, 1'h1};
    @(posedge clk) fq <= 0;
    #1 chk("fw reset,grant", {fr, fg}, e);
  endtask
  task automatic dbg(logic [15:0] a);
    @(posedge clk) {da, dq} <= {a, 1'h1};
    @(posedge clk) dq <= 0;
    #1 chk("dbg reset,grant", {fr, dg}, a < `FAP_RSVD_BASE && !lkd(a));
  endtask
  task automatic unlock;
    @(posedge clk) un <= 1;
    @(posedge clk) un <= 0;
    repeat (2) @(posedge clk);
    #1 chk("key open", ko, 1);
  endtask
  task automatic restart(logic p);
    @(posedge clk) {rst, por} <= {1'h1, p};
    repeat (10) @(posedge clk);
    {rst, por} <= 0;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    restart(1);
    @(posedge clk);
    #1 chk("lock count", lc, 3);
    dbg(16'h1FFF);
    dbg(`FAP_RSVD_BASE);
    fw(0, `FAP_RSVD_BASE, 16'h0000, 2);
    repeat (20) begin
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      dbg({3'h0, rs[12:0]});
      fw(0, rs[12:0], rs[28:16], {lkd(rs[12:0]) && !lkd(rs[28:16]),
        !lkd(rs[12:0]) || lkd(rs[28:16])});
    end
    $display("access test done");
    unlock;
    fw(1, 16'h0800, 16'h0800, 1);
    #1 chk("key relock", ko, 0);
    unlock;
    fw(2, 16'h0800, 16'h0800, 0);
    chk("key idle", kd, 0);
    fw(1, 16'h0800, 16'h0800, 0);
    chk("key dead", kd, 1);
    $display("key test done");
    restart(0);
    #1 chk("fault flag", ff, 1);
    ee <= 1;
    unlock;
    fw(2, 16'h0800, 16'h0800, 1);
    sm <= 0;
    fw(1, 16'h0800, 16'h0800, 2);
    $display("reset test done");
    complete_run;
  end
endmodule
